// file: sim/test_programmable_period_timer.sv
`timescale 1ns/1ps

module test_programmable_period_timer;
   import period_timer_pkg::*;

   logic       core_clk;
   logic       rst;
   logic       trigger;
   logic       src_reset;
   logic       hold_low;
   logic       fb_en;
   logic [7:0] fb_mask;
   wire logic  tick_in;
   wire logic  tick_oe;
   wire logic  tick_out;
   wire logic [7:0] cnt_out;
   wire logic  run_flag;
   wire logic  wired;
   wire logic  reset_req;
   wire logic [7:0] cnt_oe;
   wire logic [7:0] cnt;
   int         n_fail;
   int         comparisons;
   int         cycles = 0;

   programmable_period_timer i_dut (.core_clk(core_clk), .rst(rst), .clk_en(1'b1), .trigger(trigger),
      .reset_req(reset_req), .tick_line_in(tick_in), .tick_line_out(tick_out), .tick_line_oe(tick_oe),
      .count_outputs_out(cnt_out), .count_outputs_oe(cnt_oe), .count_value(cnt), .running(run_flag));

   timer_load_model i_load (.tick_line_oe(tick_oe), .count_outputs_oe(cnt_oe), .hold_low(hold_low),
      .fb_en(fb_en), .src_reset(src_reset), .fb_mask(fb_mask), .tick_line_in(tick_in),
      .wired_line(wired), .reset_req(reset_req));

   // ----------------------------------------------------------------
   // Clock, timeout and reporting
   // ----------------------------------------------------------------
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 60000)
      begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      if (n_fail == 0 && comparisons > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Waits a bounded time for the count to move.
   task automatic wait_chg(input int lim);
      logic [7:0] was;
      int         i;
      was = cnt;
      for (i = 0; i < lim && cnt === was; i++)
         @(negedge core_clk);
   endtask

   task automatic start();
      @(posedge core_clk) trigger <= 1'b1;
      @(posedge core_clk) trigger <= 1'b0;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk("count", 16'(cnt), 16'(COUNT_RESET));
      chk("oe", 16'(cnt_oe), 16'h0000);
      chk("running", 16'(run_flag), 16'h0000);
      chk("tick oe", 16'(tick_oe), 16'h0000);
   endtask

   task automatic t_start();
      start();
      @(negedge core_clk);
      chk("running", 16'(run_flag), 16'h0001);
      wait_chg(60);
      chk("count", 16'(cnt), 16'h0000);
      chk("oe", 16'(cnt_oe), 16'h00ff);
      chk("pin out", 16'(cnt_out), 16'h0000);
      @(posedge core_clk) trigger <= 1'b1;
      repeat (3) @(posedge core_clk);
      trigger <= 1'b0;
      wait_chg(60);
      chk("count", 16'(cnt), 16'h0001);
   endtask

   task automatic t_ctrl();
      @(posedge core_clk);
      trigger   <= 1'b1;
      src_reset <= 1'b1;
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      chk("running", 16'(run_flag), 16'h0001);
      @(posedge core_clk) trigger <= 1'b0;
      repeat (2) @(negedge core_clk);
      chk("running", 16'(run_flag), 16'h0000);
      chk("count", 16'(cnt), 16'(COUNT_RESET));
      @(posedge core_clk) src_reset <= 1'b0;
      start();
      wait_chg(60);
      @(posedge core_clk) src_reset <= 1'b1;
      @(posedge core_clk) src_reset <= 1'b0;
      repeat (3) @(negedge core_clk);
      chk("count", 16'(cnt), 16'(COUNT_RESET));
      chk("running", 16'(run_flag), 16'h0000);
      chk("tick oe", 16'(tick_oe), 16'h0000);
   endtask

   task automatic t_mono(input logic [7:0] mask);
      int n;
      n = 0;
      @(posedge core_clk);
      fb_mask <= mask;
      fb_en   <= 1'b1;
      @(posedge core_clk) trigger <= 1'b1;
      wait_chg(60);
      @(posedge core_clk) trigger <= 1'b0;
      while (wired === 1'b0 && n < 11000)
      begin
         @(negedge core_clk);
         n++;
      end
      chk("delay", 16'(n), 16'(mask * TICK_CYCLES));
      repeat (2) @(negedge core_clk);
      chk("running", 16'(run_flag), 16'h0000);
      @(posedge core_clk) fb_en <= 1'b0;
   endtask

   task automatic t_wrap();
      logic [7:0] held;
      start();
      repeat (256) wait_chg(50);
      chk("count", 16'(cnt), 16'(COUNT_MAX));
      wait_chg(50);
      chk("count", 16'(cnt), 16'h0000);
      chk("running", 16'(run_flag), 16'h0001);
      @(posedge core_clk) hold_low <= 1'b1;
      repeat (3) @(negedge core_clk);
      held = cnt;
      repeat (200) @(negedge core_clk);
      chk("count", 16'(cnt), 16'(held));
      chk("tick out", 16'(tick_out), 16'h0000);
      @(posedge core_clk) hold_low <= 1'b0;
      wait_chg(50);
      chk("count", 16'(cnt), 16'(held + 8'h01));
   endtask

   initial
   begin
      rst         = 1'b1;
      trigger     = 1'b0;
      src_reset   = 1'b0;
      hold_low    = 1'b0;
      fb_en       = 1'b0;
      fb_mask     = 8'h00;
      n_fail      = 0;
      comparisons = 0;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(negedge core_clk);
      t_reset();
      t_start();
      t_ctrl();
      t_mono(8'h01);
      t_mono(8'h31);
      t_mono(8'hff);
      t_wrap();
      end_of_test();
   end

endmodule

// file: sim/timer_load_model.sv
`timescale 1ns/1ps

module timer_load_model
(
   // Open-collector enables from the timer
   input  wire logic        tick_line_oe,
   input  wire logic [7:0]  count_outputs_oe,
   // Controls from the bench
   input  wire logic        hold_low,
   input  wire logic        fb_en,
   input  wire logic        src_reset,
   input  wire logic [7:0]  fb_mask,
   // Resolved lines
   output logic             tick_line_in,
   output logic             wired_line,
   output logic             reset_req
);

   // ----------------------------------------------------------------
   // Pull-up wires and feedback
   // ----------------------------------------------------------------
   // The tick wire is pulled up and low while any party pulls it.
   assign tick_line_in = ~(tick_line_oe | hold_low);
   // Selected outputs share one pull-up, so any low output wins.
   assign wired_line   = &(~count_outputs_oe | ~fb_mask);
   // The shared line is fed back to reset for one-shot delays.
   assign reset_req    = src_reset | (fb_en & wired_line);

endmodule

// file: verilog/period_timer_pkg.sv
package period_timer_pkg;

   // ----------------------------------------------------------------
   // Counter layout
   // ----------------------------------------------------------------
   localparam int              COUNT_WIDTH = 8;
   localparam logic [7:0]      COUNT_RESET = 8'hff;
   localparam logic [7:0]      COUNT_START = 8'h00;
   localparam logic [7:0]      COUNT_STEP  = 8'h01;
   localparam logic [7:0]      COUNT_MAX   = 8'hff;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int              CLK_PERIOD_NS    = 25;
   localparam int              TICK_PERIOD_NS   = 1000;
   localparam int              TICK_CYCLES      = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int              TICK_HALF_CYCLES = (TICK_CYCLES / 2 < 1) ? 1 : TICK_CYCLES / 2;
   localparam int              PHASE_WIDTH      = 16;
   localparam logic [15:0]     PHASE_LAST       = 16'(TICK_HALF_CYCLES - 1);
   localparam logic [15:0]     PHASE_STEP       = 16'h0001;

   // ----------------------------------------------------------------
   // Control flip-flop states
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b001,
      ST_ARMED = 3'b010,
      ST_RUN   = 3'b100
   } ctrl_state_t;

endpackage

// file: verilog/programmable_period_timer.sv
`timescale 1ns/1ps

module programmable_period_timer
   import period_timer_pkg::*;
(
   // Clock, reset and enable
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   input  wire logic                   clk_en,
   // Control inputs
   input  wire logic                   trigger,
   input  wire logic                   reset_req,
   // Tick line pin (open collector)
   input  wire logic                   tick_line_in,
   output logic                        tick_line_out,
   output logic                        tick_line_oe,
   // Binary count output pins (open collector)
   output logic [COUNT_WIDTH-1:0]      count_outputs_out,
   output logic [COUNT_WIDTH-1:0]      count_outputs_oe,
   // Status
   output logic [COUNT_WIDTH-1:0]      count_value,
   output logic                        running
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic falling(input logic prev, input logic cur);
      falling = prev & ~cur;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ctrl_state_t              state;
   ctrl_state_t              next_state;
   logic [COUNT_WIDTH-1:0]   count;
   logic [COUNT_WIDTH-1:0]   next_count;
   logic                     tick_prev;
   logic                     source_low;

   // ----------------------------------------------------------------
   // Decoding
   // ----------------------------------------------------------------
   wire                      tick_fall  = falling(tick_prev, tick_line_in);
   wire                      reset_take = reset_req & ~trigger;
   wire                      is_idle    = (state == ST_IDLE);
   wire                      is_armed   = (state == ST_ARMED);
   wire                      is_run     = (state == ST_RUN);
   wire                      start_take = is_idle & trigger;
   wire                      first_tick = is_armed & tick_fall & ~reset_take;
   wire                      count_tick = is_run & tick_fall & ~reset_take;
   wire [COUNT_WIDTH-1:0]    count_inc  = count + COUNT_STEP;

   assign next_count = reset_take ? COUNT_RESET :
                       first_tick ? COUNT_START :
                       count_tick ? count_inc   :
                       count;

   always_comb
   begin
      next_state = state;
      unique case (state)
         ST_IDLE:
         begin
            if (start_take)
            begin
               next_state = ST_ARMED;
            end
         end
         ST_ARMED:
         begin
            if (reset_take)
            begin
               next_state = ST_IDLE;
            end
            else if (tick_fall)
            begin
               next_state = ST_RUN;
            end
         end
         ST_RUN:
         begin
            if (reset_take)
            begin
               next_state = ST_IDLE;
            end
         end
         default:
         begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state     <= ST_IDLE;
         count     <= COUNT_RESET;
         tick_prev <= 1'b1;
      end
      else if (clk_en)
      begin
         state     <= next_state;
         count     <= next_count;
         tick_prev <= tick_line_in;
      end
   end

   // ----------------------------------------------------------------
   // Tick source
   // ----------------------------------------------------------------
   tick_source u_tick_source
   (
      .core_clk  (core_clk),
      .rst       (rst),
      .clk_en    (clk_en),
      .run       (running),
      .drive_low (source_low)
   );

   // ----------------------------------------------------------------
   // Pins
   // ----------------------------------------------------------------
   assign running           = ~is_idle;
   assign tick_line_out     = 1'b0;
   assign tick_line_oe      = source_low;
   assign count_outputs_out = '0;
   assign count_outputs_oe  = ~count;
   assign count_value       = count;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   idle_high_a : assert property (@(posedge core_clk) disable iff (rst)
      is_idle |-> (count == COUNT_RESET) && (count_outputs_oe == '0))
      else $error("outputs not high in reset state");

   idle_stopped_a : assert property (@(posedge core_clk) disable iff (rst)
      is_idle && $past(is_idle) && $past(clk_en) |-> !tick_line_oe)
      else $error("tick source running in reset state");

   start_arm_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && is_idle && trigger |=> is_armed && running)
      else $error("trigger did not start the tick source");

   first_low_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && is_armed && tick_fall && !reset_take |=> is_run && (count_outputs_oe == ~COUNT_START))
      else $error("first tick fall did not drive outputs low");

   trigger_ignored_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && is_run && trigger && !tick_fall |=> is_run && (count == $past(count)))
      else $error("trigger disturbed a running count");

   reset_force_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && reset_req && !trigger |=> is_idle && (count == COUNT_RESET))
      else $error("reset with trigger low not taken");

   reset_blocked_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && !is_idle && reset_req && trigger |=> !is_idle)
      else $error("reset taken while trigger high");

   late_reset_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && reset_req && $past(trigger) && !trigger |=> is_idle)
      else $error("held reset not taken at trigger fall");

   wired_and_a : assert property (@(posedge core_clk) disable iff (rst)
      (count_outputs_out == '0) && ((count_outputs_oe & count) == '0))
      else $error("output pin drives while its bit is high");

   count_step_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && is_run && tick_fall && !reset_take |=> is_run && (count == $past(count) + COUNT_STEP))
      else $error("running count did not advance by one");

   inhibit_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && !is_idle && !tick_line_in && !tick_prev && !reset_req |=> count == $past(count))
      else $error("count changed while tick line held low");

   only_fall_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && is_run && !tick_fall && !reset_take |=> count == $past(count))
      else $error("count changed without a tick fall");

   wrap_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && count_tick && (count == COUNT_MAX) |=> count == COUNT_START)
      else $error("count did not wrap to zero");

   span_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && count_tick && (count != COUNT_MAX) |=> count > $past(count))
      else $error("count did not rise toward the maximum");

   armed_wait_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && is_armed && !tick_fall && !reset_take |=> is_armed && (count == COUNT_RESET))
      else $error("armed state left without a tick fall");

   run_stay_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && is_run && !reset_take |=> is_run)
      else $error("running count stopped without a reset");

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   start_c       : cover property (@(posedge core_clk) disable iff (rst)
      is_idle ##1 is_armed ##[1:100] is_run);

   reach_max_c   : cover property (@(posedge core_clk) disable iff (rst)
      is_run && (count == COUNT_MAX));

   run_reset_c   : cover property (@(posedge core_clk) disable iff (rst)
      is_run ##1 is_idle);

   wrap_c        : cover property (@(posedge core_clk) disable iff (rst)
      is_run && (count == COUNT_MAX) ##[1:50] is_run && (count == COUNT_START));

   blocked_rst_c : cover property (@(posedge core_clk) disable iff (rst)
      is_run && reset_req && trigger ##1 is_run && reset_req && !trigger ##1 is_idle);

endmodule

// file: verilog/tick_source.sv
`timescale 1ns/1ps

module tick_source
   import period_timer_pkg::*;
(
   // Clock, reset and enable
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic clk_en,
   // Control
   input  wire logic run,
   // Open-collector pull-down of the tick line
   output logic      drive_low
);

   logic [PHASE_WIDTH-1:0] phase;
   logic                   low;

   wire                    phase_end  = (phase == PHASE_LAST);
   wire [PHASE_WIDTH-1:0]  next_phase = phase_end ? '0 : phase + PHASE_STEP;

   // ----------------------------------------------------------------
   // Half-period divider; the line starts released so the first edge is a fall.
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         phase <= '0;
         low   <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!run)
         begin
            phase <= '0;
            low   <= 1'b0;
         end
         else
         begin
            phase <= next_phase;
            if (phase_end)
            begin
               low <= ~low;
            end
         end
      end
   end

   assign drive_low = low;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   stop_release_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && !run |=> !drive_low)
      else $error("tick line still pulled low after stop");

   half_period_a : assert property (@(posedge core_clk) disable iff (rst)
      clk_en && run && !phase_end |=> drive_low == $past(drive_low))
      else $error("tick line changed before half period");

endmodule
